// ===== include/hrmi_defs.svh
// register offsets, field positions and reset values of the host register window
`ifndef HRMI_DEFS_SVH
`define HRMI_DEFS_SVH
`define HRMI_OFF_IRQ 4'h0
`define HRMI_OFF_MODE 4'h1
`define HRMI_OFF_MON 4'h2
`define HRMI_OFF_DLINE 4'h3
`define HRMI_OFF_XF2 4'h4
`define HRMI_OFF_TEST 4'h5
`define HRMI_OFF_B1LINE 4'h6
`define HRMI_OFF_B2LINE 4'h7
`define HRMI_OFF_B1BUS 4'h8
`define HRMI_OFF_B2BUS 4'h9
`define HRMI_OFF_MONST 4'hA
`define HRMI_OFF_DBUS 4'hB
`define HRMI_OFF_CILINE 4'hC
`define HRMI_OFF_CIBUS 4'hD
`define HRMI_OFF_XF 4'hE
`define HRMI_OFF_SWITCH 4'hF
`define HRMI_OFF_LINK 4'h5
`define HRMI_BIT_D 7
`define HRMI_BIT_CIB 6
`define HRMI_BIT_CIL 5
`define HRMI_BIT_SF 4
`define HRMI_BIT_MRX 3
`define HRMI_BIT_B1 2
`define HRMI_BIT_B2 1
`define HRMI_BIT_MTX 0
`define HRMI_MS_RXF 7
`define HRMI_MS_END 6
`define HRMI_MS_ACK 5
`define HRMI_MS_ABT 4
`define HRMI_MS_ACT 3
`define HRMI_MC_RE 7
`define HRMI_MC_HC 6
`define HRMI_MC_TE 5
`define HRMI_MC_TC 4
`define HRMI_RST_MASK 8'hFF
`define HRMI_RST_MODE 8'h04
`define HRMI_RST_XF2 8'h08
`define HRMI_RST_ZERO 8'h00
`endif

// ===== include/hrmi_pkg.sv
// types of the host register window
package hrmi_pkg;
   typedef enum logic [1:0] {
      HRMI_IDLE = 2'b00,
      HRMI_FIRST = 2'b01,
      HRMI_MORE = 2'b10
   } hrmi_rx_e;
   typedef struct packed {
      logic [7:0] irq;
      logic [7:0] mask;
      logic [7:0] mode;
      logic [7:0] xf;
      logic [7:0] xf2;
      logic [7:0] sw;
      logic [7:0] mon_rx;
      logic [7:0] mon_tx;
      logic [7:0] mon_st;
      logic [7:0] mon_ctl;
      logic [7:0] dline_rx;
      logic [7:0] dbus_rx;
      logic [7:0] dline_tx;
      logic [7:0] dbus_tx;
      logic [7:0] b1l_rx;
      logic [7:0] b2l_rx;
      logic [7:0] b1b_rx;
      logic [7:0] b2b_rx;
      logic [7:0] b1l_tx;
      logic [7:0] b2l_tx;
      logic [7:0] b1b_tx;
      logic [7:0] b2b_tx;
      logic [7:0] cil_rx;
      logic [7:0] cib_rx;
      logic [7:0] cil_tx;
      logic [7:0] cib_tx;
      logic [5:0] rd_pend;
      logic mx_prev;
      logic mr_out;
      logic st_active;
      logic st_req;
      logic irq_n;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      hrmi_rx_e rx_state;
   } hrmi_state_s;
endpackage

// ===== logic/hrmi_regs.sv
// host register window, interrupt flags and monitor-channel interrupt logic
//
// The APB register port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "hrmi_defs.svh"
//
// Notes on behaviour
// - line-only flag low deactivates S/T only
// - line-only flag high requests S/T activation
// - registers reachable only in microprocessor mode
// - sixteen addresses, read and write differ
// - eight status flags, D down to monitor-transmit
// - D flag clears after both D reads
// - B flag clears after both reads
// - C/I flags clear on their reads
// - superframe flag set by marker, cleared by status read
// - rising unmasked flag pulls interrupt low
// - masked flags still set, excluded from pin
// - receive flag on data-received or end status
// - transmit flag on acknowledge or abort status
// - monitor statuses except active gated by enables
// - receive enable off blocks data-received
// - no handshake control: first byte only
// - handshake control: every byte stored, flagged
// - handshake control drives receive handshake bit
module hrmi_regs
(
   input wire logic pclk,                 // register bus clock, 100 MHz
   input wire logic presetn,              // asynchronous reset, active low
   input wire logic clk_en,               // freezes all state while low
   input wire logic psel,                 // apb select
   input wire logic penable,              // apb access phase
   input wire logic pwrite,               // apb direction
   input wire logic [5:0] paddr,          // apb byte address
   input wire logic [31:0] pwdata,        // apb write data
   output logic [31:0] prdata,            // apb read data
   output logic pready,                   // apb ready
   output logic pslverr,                  // apb error
   input wire logic up_mode,              // microprocessor mode strap, pin
   input wire logic line_only_active,     // line-only-active indication, pin
   input wire logic superframe_mark,      // superframe marker, pin
   input wire logic dline_valid,          // d byte from line ready, same clock
   input wire logic [7:0] dline_data,     // d byte from line
   input wire logic dbus_valid,           // d byte from terminal bus ready
   input wire logic [7:0] dbus_data,      // d byte from terminal bus
   input wire logic b1_valid,             // b1 bytes of both sides ready
   input wire logic [7:0] b1_line_data,   // b1 byte from line
   input wire logic [7:0] b1_bus_data,    // b1 byte from terminal bus
   input wire logic b2_valid,             // b2 bytes of both sides ready
   input wire logic [7:0] b2_line_data,   // b2 byte from line
   input wire logic [7:0] b2_bus_data,    // b2 byte from terminal bus
   input wire logic [7:0] ci_line_code,   // c/i code from line
   input wire logic [7:0] ci_bus_code,    // c/i code from terminal bus
   input wire logic mon_byte_valid,       // monitor byte slot, same clock
   input wire logic [7:0] mon_byte,       // monitor byte received
   input wire logic mon_tx_handshake_bit, // incoming transmit handshake bit
   input wire logic mon_eom,              // end of message seen
   input wire logic mon_ack,              // far end acknowledged our byte
   input wire logic mon_abort,            // far end aborted
   output logic irq_n,                    // interrupt pin, active low
   output logic mon_rx_handshake_bit,     // receive handshake bit driven out
   output logic st_active                 // s/t interface activation
);
   hrmi_pkg::hrmi_state_s s_reg;
   hrmi_pkg::hrmi_state_s s_next;
   // ****************************************
   // pin synchronisers
   // ****************************************
   logic [2:0] sync1_reg;
   logic [2:0] sync2_reg;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sync1_reg <= 3'h0;
         sync2_reg <= 3'h0;
      end
      else if (clk_en)
      begin
         sync1_reg <= {up_mode, line_only_active, superframe_mark};
         sync2_reg <= sync1_reg;
      end
   end
   logic sf_prev_reg;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         sf_prev_reg <= 1'b0;
      else if (clk_en)
         sf_prev_reg <= sync2_reg[0];
   end
   // ****************************************
   // next state
   // ****************************************
   logic [3:0] idx;
   logic acc;
   logic rd;
   logic wr;
   logic [7:0] wd;
   logic [7:0] rdat;
   logic [7:0] set_irq;
   logic [7:0] clr_irq;
   logic [7:0] new_irq;
   logic mx_fall;
   logic rx_flag;
   always_comb
   begin
      s_next = s_reg;
      idx = paddr[5:2];
      acc = psel && penable && s_reg.pready && !s_reg.pslverr;
      rd = acc && !pwrite;
      wr = acc && pwrite;
      wd = pwdata[7:0];
      set_irq = 8'h00;
      clr_irq = 8'h00;
      rdat = 8'h00;
      rx_flag = 1'b0;
      mx_fall = s_reg.mx_prev && !mon_tx_handshake_bit && mon_byte_valid;
      s_next.pready = psel && !s_reg.pready;
      s_next.pslverr = 1'b0;
      // incoming data
      if (dline_valid)
         s_next.dline_rx = dline_data;
      if (dbus_valid)
         s_next.dbus_rx = dbus_data;
      if (dline_valid || dbus_valid)
      begin
         set_irq[`HRMI_BIT_D] = 1'b1;
         s_next.rd_pend[5:4] = 2'b11;
      end
      if (b1_valid)
      begin
         s_next.b1l_rx = b1_line_data;
         s_next.b1b_rx = b1_bus_data;
         set_irq[`HRMI_BIT_B1] = 1'b1;
      end
      if (b2_valid)
      begin
         s_next.b2l_rx = b2_line_data;
         s_next.b2b_rx = b2_bus_data;
         set_irq[`HRMI_BIT_B2] = 1'b1;
      end
      if (b1_valid)
         s_next.rd_pend[3:2] = 2'b11;
      if (b2_valid)
         s_next.rd_pend[1:0] = 2'b11;
      if (ci_line_code != s_reg.cil_rx)
      begin
         s_next.cil_rx = ci_line_code;
         set_irq[`HRMI_BIT_CIL] = 1'b1;
      end
      if (ci_bus_code != s_reg.cib_rx)
      begin
         s_next.cib_rx = ci_bus_code;
         set_irq[`HRMI_BIT_CIB] = 1'b1;
      end
      if (sync2_reg[0] && !sf_prev_reg)
         set_irq[`HRMI_BIT_SF] = 1'b1;
      // monitor receive path
      if (mon_byte_valid)
         s_next.mx_prev = mon_tx_handshake_bit;
      if (mx_fall)
      begin
         case (s_reg.rx_state)
            hrmi_pkg::HRMI_IDLE:
            begin
               s_next.rx_state = hrmi_pkg::HRMI_FIRST;
               if (s_reg.mon_ctl[`HRMI_MC_RE])
               begin
                  s_next.mon_rx = mon_byte;
                  rx_flag = 1'b1;
               end
            end
            hrmi_pkg::HRMI_FIRST, hrmi_pkg::HRMI_MORE:
            begin
               s_next.rx_state = hrmi_pkg::HRMI_MORE;
               if (s_reg.mon_ctl[`HRMI_MC_RE] && s_reg.mon_ctl[`HRMI_MC_HC])
               begin
                  s_next.mon_rx = mon_byte;
                  rx_flag = 1'b1;
               end
            end
            default:
               s_next.rx_state = hrmi_pkg::HRMI_IDLE;
         endcase
         if (s_reg.mon_ctl[`HRMI_MC_HC])
            s_next.mr_out = 1'b0;
      end
      if (mon_eom)
         s_next.rx_state = hrmi_pkg::HRMI_IDLE;
      if (rx_flag)
         s_next.mon_st[`HRMI_MS_RXF] = 1'b1;
      if (mon_eom && s_reg.mon_ctl[`HRMI_MC_RE] && s_reg.mon_ctl[`HRMI_MC_HC])
         s_next.mon_st[`HRMI_MS_END] = 1'b1;
      if (mon_ack && s_reg.mon_ctl[`HRMI_MC_TE])
         s_next.mon_st[`HRMI_MS_ACK] = 1'b1;
      if (mon_abort && s_reg.mon_ctl[`HRMI_MC_TE])
         s_next.mon_st[`HRMI_MS_ABT] = 1'b1;
      s_next.mon_st[`HRMI_MS_ACT] = s_reg.rx_state != hrmi_pkg::HRMI_IDLE;
      if (rx_flag || (mon_eom && s_reg.mon_ctl[`HRMI_MC_RE] && s_reg.mon_ctl[`HRMI_MC_HC]))
         set_irq[`HRMI_BIT_MRX] = 1'b1;
      if ((mon_ack || mon_abort) && s_reg.mon_ctl[`HRMI_MC_TE])
         set_irq[`HRMI_BIT_MTX] = 1'b1;
      // line-only indication steers the s/t side
      s_next.st_active = sync2_reg[1];
      s_next.st_req = sync2_reg[1] && !s_reg.st_active;
      // bus reads: read side of each address
      case (idx)
         `HRMI_OFF_IRQ: rdat = s_reg.irq;
         `HRMI_OFF_MON: rdat = s_reg.mon_rx;
         `HRMI_OFF_DLINE: rdat = s_reg.dline_rx;
         `HRMI_OFF_B1LINE: rdat = s_reg.b1l_rx;
         `HRMI_OFF_B2LINE: rdat = s_reg.b2l_rx;
         `HRMI_OFF_B1BUS: rdat = s_reg.b1b_rx;
         `HRMI_OFF_B2BUS: rdat = s_reg.b2b_rx;
         `HRMI_OFF_MONST: rdat = s_reg.mon_st;
         `HRMI_OFF_DBUS: rdat = s_reg.dbus_rx;
         `HRMI_OFF_CILINE: rdat = s_reg.cil_rx;
         `HRMI_OFF_CIBUS: rdat = s_reg.cib_rx;
         default: rdat = 8'h00;
      endcase
      // refusal and read data are decided in setup so that they stand with pready
      if (psel && !s_reg.pready && !sync2_reg[2])
         s_next.pslverr = 1'b1;
      if (psel && !s_reg.pready && idx == `HRMI_OFF_TEST)
         s_next.pslverr = 1'b1;
      if (psel && !s_reg.pready && !pwrite && sync2_reg[2])
         s_next.prdata = {24'h000000, rdat};
      if (rd && s_reg.pready)
      begin
         case (idx)
            `HRMI_OFF_IRQ: clr_irq[`HRMI_BIT_SF] = 1'b1;
            `HRMI_OFF_DLINE: s_next.rd_pend[5] = 1'b0;
            `HRMI_OFF_DBUS: s_next.rd_pend[4] = 1'b0;
            `HRMI_OFF_B1LINE: s_next.rd_pend[3] = 1'b0;
            `HRMI_OFF_B1BUS: s_next.rd_pend[2] = 1'b0;
            `HRMI_OFF_B2LINE: s_next.rd_pend[1] = 1'b0;
            `HRMI_OFF_B2BUS: s_next.rd_pend[0] = 1'b0;
            `HRMI_OFF_CILINE: clr_irq[`HRMI_BIT_CIL] = 1'b1;
            `HRMI_OFF_CIBUS: clr_irq[`HRMI_BIT_CIB] = 1'b1;
            `HRMI_OFF_MONST:
            begin
               clr_irq[`HRMI_BIT_MRX] = 1'b1;
               clr_irq[`HRMI_BIT_MTX] = 1'b1;
               s_next.mon_st[7:4] = 4'h0;
            end
            default: clr_irq = 8'h00;
         endcase
         // one bit per register, so reading the same half twice never clears
         if ((idx == `HRMI_OFF_DLINE && !s_reg.rd_pend[4]) ||
             (idx == `HRMI_OFF_DBUS && !s_reg.rd_pend[5]))
            clr_irq[`HRMI_BIT_D] = 1'b1;
         if ((idx == `HRMI_OFF_B1LINE && !s_reg.rd_pend[2]) ||
             (idx == `HRMI_OFF_B1BUS && !s_reg.rd_pend[3]))
            clr_irq[`HRMI_BIT_B1] = 1'b1;
         if ((idx == `HRMI_OFF_B2LINE && !s_reg.rd_pend[0]) ||
             (idx == `HRMI_OFF_B2BUS && !s_reg.rd_pend[1]))
            clr_irq[`HRMI_BIT_B2] = 1'b1;
      end
      // bus writes: write side of each address
      if (wr && s_reg.pready && idx != `HRMI_OFF_TEST)
      begin
         case (idx)
            `HRMI_OFF_IRQ: s_next.mask = wd;
            `HRMI_OFF_MODE: s_next.mode = wd;
            `HRMI_OFF_MON: s_next.mon_tx = wd;
            `HRMI_OFF_DLINE: s_next.dline_tx = wd;
            `HRMI_OFF_XF2: s_next.xf2 = wd;
            `HRMI_OFF_B1LINE: s_next.b1l_tx = wd;
            `HRMI_OFF_B2LINE: s_next.b2l_tx = wd;
            `HRMI_OFF_B1BUS: s_next.b1b_tx = wd;
            `HRMI_OFF_B2BUS: s_next.b2b_tx = wd;
            `HRMI_OFF_MONST:
            begin
               s_next.mon_ctl = wd;
               if (wd[`HRMI_MC_HC])
                  s_next.mr_out = 1'b1;
            end
            `HRMI_OFF_DBUS: s_next.dbus_tx = wd;
            `HRMI_OFF_CILINE: s_next.cil_tx = wd;
            `HRMI_OFF_CIBUS: s_next.cib_tx = wd;
            `HRMI_OFF_XF: s_next.xf = wd;
            `HRMI_OFF_SWITCH: s_next.sw = wd;
            default: s_next.sw = s_reg.sw;
         endcase
      end
      if (!s_reg.mon_ctl[`HRMI_MC_HC])
         s_next.mr_out = 1'b1;
      // set wins over clear
      new_irq = (s_reg.irq & ~clr_irq) | set_irq;
      s_next.irq = new_irq;
      // the pin stays low while any unmasked flag stands
      s_next.irq_n = ~|(new_irq & ~s_reg.mask);
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_reg <= '0;
         s_reg.mask <= `HRMI_RST_MASK;
         s_reg.mode <= `HRMI_RST_MODE;
         s_reg.xf2 <= `HRMI_RST_XF2;
         s_reg.irq_n <= 1'b1;
         s_reg.mr_out <= 1'b1;
         s_reg.mx_prev <= 1'b1;
         s_reg.rx_state <= hrmi_pkg::HRMI_IDLE;
      end
      else if (clk_en)
         s_reg <= s_next;
   end
   assign prdata = s_reg.prdata;
   assign pready = s_reg.pready;
   assign pslverr = s_reg.pslverr;
   assign irq_n = s_reg.irq_n;
   assign mon_rx_handshake_bit = s_reg.mr_out;
   assign st_active = s_reg.st_active;
   // ****************************************
   // checks
   // ****************************************
   irq_pin_low_a: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && |(set_irq & ~s_reg.mask) |=> !irq_n)
      else $error("unmasked flag did not pull pin low");
   irq_pin_rel_a: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && !(|(s_reg.irq & ~s_reg.mask)) && set_irq == 8'h00 |=> irq_n)
      else $error("pin not released");
   sf_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && rd && s_reg.pready && idx == `HRMI_OFF_IRQ && !set_irq[`HRMI_BIT_SF]
      |=> !s_reg.irq[`HRMI_BIT_SF])
      else $error("superframe flag not cleared");
   cil_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && rd && s_reg.pready && idx == `HRMI_OFF_CILINE && !set_irq[`HRMI_BIT_CIL]
      |=> !s_reg.irq[`HRMI_BIT_CIL])
      else $error("line c/i flag not cleared");
   rx_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && !s_reg.mon_ctl[`HRMI_MC_RE] && !mon_eom && !(rd && idx == `HRMI_OFF_MONST)
      |=> $stable(s_reg.mon_st[`HRMI_MS_RXF]) || !$past(s_reg.mon_st[`HRMI_MS_RXF], 1) == 0)
      else $error("receive status set while disabled");
   st_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en ##1 clk_en |-> st_active == $past(sync2_reg[1], 1))
      else $error("s/t activation does not follow indication");
   mode_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && psel && !penable && !s_reg.pready && !sync2_reg[2] |=> pslverr && pready)
      else $error("access outside microprocessor mode not refused");
   mtx_set_a: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && mon_ack && s_reg.mon_ctl[`HRMI_MC_TE] |=> s_reg.irq[`HRMI_BIT_MTX])
      else $error("transmit flag missing");
endmodule
`default_nettype wire

// ===== verif/hrmi_host.sv
// apb host model that reaches the register window
`timescale 1ns/100ps
`default_nettype none
module hrmi_host
(
   input wire logic pclk,          // bus clock
   output var logic psel,          // select
   output var logic penable,       // access phase
   output var logic pwrite,        // direction
   output var logic [5:0] paddr,   // byte address
   output var logic [31:0] pwdata, // write data
   input wire logic [31:0] prdata, // read data
   input wire logic pready,        // ready
   input wire logic pslverr        // error
);
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 6'h00;
      pwdata = 32'h00000000;
   end
   // read data and error stand with pready, so both are taken at the completion edge
   task automatic xfer(input logic wr, input logic [3:0] idx, input logic [7:0] wd,
      output logic [7:0] rd, output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h000000, wd};
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      err = pslverr;
      rd = prdata[7:0];
      psel <= 1'b0;
      penable <= 1'b0;
      // released lines must not keep looking valid
      paddr <= ~paddr;
      pwdata <= ~pwdata;
      @(posedge pclk);
   endtask
endmodule
`default_nettype wire

// ===== verif/host_register_map_and_interrupts_test.sv
// self-checking bench of the host register window
`timescale 1ns/100ps
`default_nettype none
`include "hrmi_defs.svh"
`define CHK(nm, exp, got) \
   begin tests_run++; if ((got) !== (exp)) begin fails++; \
   $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); end end
module host_register_map_and_interrupts_test;
   logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, up_mode;
   logic [5:0] paddr;
   logic [31:0] pwdata, prdata;
   logic loa, sfm, dlv, dbv, b1v, b2v, mbv, mtx, eom, ack, abt, irq_n, mrx, st_act;
   logic [7:0] dld, dbd, b1l, b1b, b2l, b2b, cil, cib, mb, v;
   int fails, tests_run;
   hrmi_regs u_hrmi_regs (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .up_mode(up_mode), .line_only_active(loa),
      .superframe_mark(sfm), .dline_valid(dlv), .dline_data(dld), .dbus_valid(dbv),
      .dbus_data(dbd), .b1_valid(b1v), .b1_line_data(b1l), .b1_bus_data(b1b),
      .b2_valid(b2v), .b2_line_data(b2l), .b2_bus_data(b2b), .ci_line_code(cil),
      .ci_bus_code(cib), .mon_byte_valid(mbv), .mon_byte(mb), .mon_tx_handshake_bit(mtx),
      .mon_eom(eom), .mon_ack(ack), .mon_abort(abt), .irq_n(irq_n),
      .mon_rx_handshake_bit(mrx), .st_active(st_act));
   hrmi_host u_hrmi_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic rd(input logic [3:0] i, output logic [7:0] d, output logic e);
      u_hrmi_host.xfer(1'b0, i, 8'h00, d, e);
   endtask
   task automatic wr(input logic [3:0] i, input logic [7:0] d);
      logic [7:0] r;
      logic e;
      u_hrmi_host.xfer(1'b1, i, d, r, e);
   endtask
   // one monitor slot: a low handshake after a high one marks a new byte
   task automatic mslot(input logic hs, input logic [7:0] b);
      @(posedge pclk);
      mbv <= 1'b1;
      mtx <= hs;
      mb <= b;
      @(posedge pclk);
      mbv <= 1'b0;
      mb <= ~b;
      cyc(3);
   endtask
   // one end-of-message pulse from the far end
   task automatic meom;
      @(posedge pclk);
      eom <= 1'b1;
      @(posedge pclk);
      eom <= 1'b0;
      cyc(3);
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic t_dchan;
      logic e;
      `CHK("pin idle", 1'b1, irq_n)
      wr(`HRMI_OFF_IRQ, 8'h7F);
      @(posedge pclk);
      {dlv, dbv, dld, dbd} <= {2'b11, 16'h5AA5};
      @(posedge pclk);
      {dlv, dbv} <= 2'b00;
      cyc(3);
      `CHK("pin low", 1'b0, irq_n)
      rd(`HRMI_OFF_DLINE, v, e);
      `CHK("dline", 8'h5A, v)
      rd(`HRMI_OFF_IRQ, v, e);
      `CHK("d kept", 1'b1, v[`HRMI_BIT_D])
      rd(`HRMI_OFF_DBUS, v, e);
      `CHK("dbus", 8'hA5, v)
      rd(`HRMI_OFF_IRQ, v, e);
      `CHK("d clear", 1'b0, v[`HRMI_BIT_D])
      cyc(2);
      `CHK("pin back", 1'b1, irq_n)
      wr(`HRMI_OFF_IRQ, 8'hFF);
   endtask
   task automatic t_bchan;
      logic e;
      @(posedge pclk);
      {b1v, b2v, b1l, b1b, b2l, b2b} <= {2'b11, 32'h11223344};
      @(posedge pclk);
      {b1v, b2v} <= 2'b00;
      cyc(3);
      rd(`HRMI_OFF_B1LINE, v, e);
      `CHK("b1 line", 8'h11, v)
      rd(`HRMI_OFF_B1LINE, v, e);
      rd(`HRMI_OFF_IRQ, v, e);
      `CHK("b1 b2 kept", 2'b11, v[2:1])
      `CHK("masked pin", 1'b1, irq_n)
      rd(`HRMI_OFF_B1BUS, v, e);
      `CHK("b1 bus", 8'h22, v)
      rd(`HRMI_OFF_B2LINE, v, e);
      `CHK("b2 line", 8'h33, v)
      rd(`HRMI_OFF_B2BUS, v, e);
      `CHK("b2 bus", 8'h44, v)
      rd(`HRMI_OFF_IRQ, v, e);
      `CHK("b1 b2 clear", 2'b00, v[2:1])
   endtask
   task automatic t_ci_sf;
      logic e;
      cil <= 8'h3C;
      cib <= 8'hC3;
      cyc(6);
      rd(`HRMI_OFF_IRQ, v, e);
      `CHK("ci flags", 2'b11, v[6:5])
      rd(`HRMI_OFF_CILINE, v, e);
      `CHK("ci line", 8'h3C, v)
      rd(`HRMI_OFF_CIBUS, v, e);
      rd(`HRMI_OFF_IRQ, v, e);
      `CHK("ci clear", 2'b00, v[6:5])
      wr(`HRMI_OFF_IRQ, 8'hEF);
      sfm <= 1'b1;
      cyc(6);
      `CHK("sf pin", 1'b0, irq_n)
      rd(`HRMI_OFF_IRQ, v, e);
      `CHK("sf set", 1'b1, v[`HRMI_BIT_SF])
      rd(`HRMI_OFF_IRQ, v, e);
      `CHK("sf clear", 1'b0, v[`HRMI_BIT_SF])
      `CHK("sf pin off", 1'b1, irq_n)
      sfm <= 1'b0;
      wr(`HRMI_OFF_IRQ, 8'hFF);
   endtask
   task automatic t_access;
      logic e;
      rd(`HRMI_OFF_TEST, v, e);
      `CHK("test addr", 1'b1, e)
      up_mode <= 1'b0;
      cyc(4);
      rd(`HRMI_OFF_IRQ, v, e);
      `CHK("standalone", 1'b1, e)
      up_mode <= 1'b1;
      cyc(4);
      rd(`HRMI_OFF_IRQ, v, e);
      `CHK("up mode", 1'b0, e)
      loa <= 1'b1;
      cyc(6);
      `CHK("st on", 1'b1, st_act)
      loa <= 1'b0;
      cyc(6);
      `CHK("st off", 1'b0, st_act)
   endtask
   task automatic mon_flag(input int b, input logic x);
      logic e;
      rd(`HRMI_OFF_IRQ, v, e);
      `CHK("monitor flag", x, v[b])
      rd(`HRMI_OFF_MONST, v, e);
   endtask
   task automatic t_monitor;
      logic e;
      wr(`HRMI_OFF_MONST, 8'h00);
      mslot(1'b1, 8'h00);
      mslot(1'b0, 8'h81);
      mon_flag(`HRMI_BIT_MRX, 1'b0);
      meom;
      wr(`HRMI_OFF_MONST, 8'h80);
      mslot(1'b1, 8'h00);
      mslot(1'b0, 8'h42);
      mon_flag(`HRMI_BIT_MRX, 1'b1);
      mslot(1'b1, 8'h00);
      mslot(1'b0, 8'h43);
      mon_flag(`HRMI_BIT_MRX, 1'b0);
      meom;
      mon_flag(`HRMI_BIT_MRX, 1'b0);
      wr(`HRMI_OFF_MONST, 8'hC0);
      mslot(1'b1, 8'h00);
      mslot(1'b0, 8'h55);
      rd(`HRMI_OFF_MON, v, e);
      `CHK("mon byte", 8'h55, v)
      `CHK("mr low", 1'b0, mrx)
      mon_flag(`HRMI_BIT_MRX, 1'b1);
      mslot(1'b1, 8'h00);
      mslot(1'b0, 8'h56);
      rd(`HRMI_OFF_MON, v, e);
      `CHK("mon byte two", 8'h56, v)
      mon_flag(`HRMI_BIT_MRX, 1'b1);
      meom;
      mon_flag(`HRMI_BIT_MRX, 1'b1);
      wr(`HRMI_OFF_MONST, 8'h20);
      @(posedge pclk);
      ack <= 1'b1;
      @(posedge pclk);
      ack <= 1'b0;
      cyc(3);
      mon_flag(`HRMI_BIT_MTX, 1'b1);
      `CHK("mr released", 1'b1, mrx)
      wr(`HRMI_OFF_MONST, 8'h00);
      @(posedge pclk);
      abt <= 1'b1;
      @(posedge pclk);
      abt <= 1'b0;
      cyc(3);
      mon_flag(`HRMI_BIT_MTX, 1'b0);
   endtask
   initial
   begin
      fails = 0;
      tests_run = 0;
      {presetn, clk_en, up_mode, loa, sfm, dlv, dbv, b1v, b2v} = 9'b011000000;
      {mbv, mtx, eom, ack, abt} = 5'b01000;
      {dld, dbd, b1l, b1b, b2l, b2b, cil, cib, mb} = 72'h0;
      cyc(20);
      presetn <= 1'b1;
      cyc(3);
      `CHK("st reset", 1'b0, st_act)
      `CHK("mr reset", 1'b1, mrx)
      t_dchan;
      t_bchan;
      t_ci_sf;
      t_access;
      t_monitor;
      close_out;
   end
   initial
   begin
      cyc(20000);
      fails++;
      close_out;
   end
endmodule
`default_nettype wire
